// *** pkg/dsrc_pkg.sv ***
`default_nettype none
package dsrc_pkg;
  // ------------------------------------------------------------
  // register bus geometry
  // ------------------------------------------------------------
  localparam int          DSRC_DW        = 16;
  localparam int          DSRC_AW        = 4;

  // ------------------------------------------------------------
  // register word offsets
  // ------------------------------------------------------------
  localparam logic [3:0]  ADR_SYSCTL     = 4'h0;
  localparam logic [3:0]  ADR_STATUS     = 4'h1;
  localparam logic [3:0]  ADR_MASK       = 4'h2;
  localparam logic [3:0]  ADR_RC2        = 4'h4;
  localparam int          RC2_WORDS      = 10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int          SYS_RUN        = 0;
  localparam int          SYS_BRK        = 1;
  localparam int          SYS_DBM        = 2;
  localparam int          ST_SUSP        = 0;
  localparam int          ST_TRAP        = 1;

  // ------------------------------------------------------------
  // encodings and reset values
  // ------------------------------------------------------------
  localparam logic [1:0]  DBM_MANUAL     = 2'h2;
  localparam logic [1:0]  DBM_RST        = 2'h0;
  localparam logic [1:0]  FLAGS_RST      = 2'h0;
  localparam logic [1:0]  MASK_RST       = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } dsrc_state_t;
endpackage
`default_nettype wire

// *** pkg/dsrc_snap_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dsrc_snap_if #(
  parameter int N = 10,
  parameter int W = 16
);
  logic             cap;
  logic [N*W-1:0]   state;
  logic [3:0]       idx;
  logic [W-1:0]     rdata;

  modport ctrl  (output cap, output state, output idx, input rdata);
  modport store (input cap, input state, input idx, output rdata);
endinterface
`default_nettype wire

// *** hdl/dsrc_snap.sv ***
`timescale 1ns/1ps
`default_nettype none
// rendering control register 2: engine context captured at a break
module dsrc_snap #(
  parameter int N = 10,
  parameter int W = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // capture and read side
  dsrc_snap_if.store sp
);
  logic [W-1:0] mem [N];

  generate
    for (genvar i = 0; i < N; i++)
    begin : g_word
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem[i] <= '0;
        else if (sp.cap)
          mem[i] <= sp.state[i*W +: W];
      end
    end
  endgenerate

  // out of range index reads as zero
  assign sp.rdata = (int'(sp.idx) < N) ? mem[sp.idx] : '0;
endmodule
`default_nettype wire

// *** hdl/dsrc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsrc_top
  import dsrc_pkg::*;
#(
  parameter int N = RC2_WORDS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // register port
  input  wire logic [DSRC_AW-1:0]   addr,
  input  wire logic [DSRC_DW-1:0]   wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output var  logic [DSRC_DW-1:0]   rdata,
  // drawing engine
  input  wire logic                 top_of_cmd,
  input  wire logic                 trap_hit,
  input  wire logic [N*DSRC_DW-1:0] engine_state,
  output var  logic                 engine_run,
  output var  logic                 cmd_go,
  // interrupt
  output var  logic                 irq
);
  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (N < 1 || int'(ADR_RC2) + N > 16)
  begin : g_bad_n
    $error("context word count does not fit the register map");
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  dsrc_state_t state;
  dsrc_state_t next_state;
  logic [1:0]  double_buffer_mode_field;
  logic        brk_pend;
  logic [1:0]  flags;
  logic [1:0]  mask;

  dsrc_snap_if #(.N(N), .W(DSRC_DW)) sp ();

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire       wr_sys    = wr && (addr == ADR_SYSCTL);
  wire       wr_stat   = wr && (addr == ADR_STATUS);
  wire       wr_mask   = wr && (addr == ADR_MASK);
  wire       manual    = (double_buffer_mode_field == DBM_MANUAL);
  wire       running   = (state == ST_RUN);
  wire       run_req   = wr_sys && wdata[SYS_RUN];
  // break only accepted in manual display change mode
  wire       brk_req   = wr_sys && wdata[SYS_BRK]
                         && (wdata[SYS_DBM +: 2] == DBM_MANUAL);
  wire       take_brk  = running && top_of_cmd && brk_pend
                         && manual;
  wire       grant     = running && top_of_cmd && !take_brk;
  wire       trap_end  = running && trap_hit && !take_brk;
  wire [1:0] flag_set  = {trap_end, take_brk};
  wire [1:0] flag_clr  = wr_stat ? wdata[1:0] : 2'h0;
  wire [1:0] next_flags = (flags & ~flag_clr) | flag_set;
  wire [1:0] next_mask = wr_mask ? wdata[1:0] : mask;
  wire       next_irq  = |(next_flags & next_mask);
  wire       next_brk  = (brk_pend || brk_req) && !take_brk && !trap_end;

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (run_req)
          next_state = ST_RUN;
      ST_RUN:
        if (take_brk)
          next_state = ST_HALT;
        else if (trap_end)
          next_state = ST_IDLE;
      ST_HALT:
        if (run_req)
          next_state = ST_RUN;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      double_buffer_mode_field      <= DBM_RST;
      brk_pend <= 1'b0;
      flags    <= FLAGS_RST;
      mask     <= MASK_RST;
    end
    else
    begin
      if (wr_sys)
        double_buffer_mode_field <= wdata[SYS_DBM +: 2];
      brk_pend <= next_brk;
      flags    <= next_flags;
      mask     <= next_mask;
    end
  end

  // run bit reads back as 1 until the list ends or breaks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      engine_run <= 1'b0;
      cmd_go     <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      engine_run <= (next_state == ST_RUN);
      cmd_go     <= grant;
      irq        <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // context snapshot
  // ------------------------------------------------------------
  assign sp.cap   = take_brk;
  assign sp.state = engine_state;
  assign sp.idx   = addr - ADR_RC2;

  dsrc_snap #(.N(N), .W(DSRC_DW)) u_snap (
    .clk   (clk),
    .rst_n (rst_n),
    .sp    (sp.store)
  );

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // context words are what the host saves for the restore list
  wire in_rc2 = (addr >= ADR_RC2)
                && (int'(addr) < int'(ADR_RC2) + N);
  wire [DSRC_DW-1:0] sys_word =
    {12'h000, double_buffer_mode_field, brk_pend, engine_run};
  wire [DSRC_DW-1:0] next_rdata =
    !rd                   ? 16'h0000 :
    (addr == ADR_SYSCTL)  ? sys_word :
    (addr == ADR_STATUS)  ? {14'h0000, flags} :
    (addr == ADR_MASK)    ? {14'h0000, mask} :
    in_rc2                ? sp.rdata : 16'h0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_break_halts: assert property (
    take_brk |=> !engine_run && (state == ST_HALT) && !cmd_go)
    else $error("break did not halt the engine");

  a_susp_flag: assert property (
    take_brk |=> flags[ST_SUSP])
    else $error("suspended flag not set after break");

  a_trap_flag: assert property (
    trap_end |=> flags[ST_TRAP] && !engine_run && !brk_pend)
    else $error("trap end not recorded");

  a_brk_gated: assert property (
    wr_sys && wdata[SYS_BRK] && (wdata[SYS_DBM +: 2] != DBM_MANUAL)
    && !brk_pend |=> !brk_pend)
    else $error("break accepted outside manual mode");

  a_brk_pending: assert property (
    brk_req && !running |=> brk_pend ##0 $stable(flags[ST_SUSP]))
    else $error("break request not held pending");

  a_run_start: assert property (
    run_req && (state != ST_RUN) |=> engine_run)
    else $error("run bit did not start drawing");

  a_go_grant: assert property (
    grant |=> cmd_go ##1 !cmd_go || top_of_cmd)
    else $error("command not granted for one cycle");

  a_set_wins: assert property (
    take_brk && wr_stat && wdata[ST_SUSP] |=> flags[ST_SUSP])
    else $error("flag clear beat a new event");

  a_snap_word: assert property (
    take_brk |=> ##1 (u_snap.mem[0] == $past(engine_state[15:0], 2)))
    else $error("context word 0 not captured");

  a_irq_level: assert property (
    irq == |(flags & mask))
    else $error("interrupt does not follow status and mask");

  a_rd_status: assert property (
    rd && (addr == ADR_STATUS) |=> rdata == {14'h0000, $past(flags)})
    else $error("status read data wrong");

  a_no_go_idle: assert property (
    !running |=> !cmd_go)
    else $error("command granted while not running");

  a_rdata_zero: assert property (
    !rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");

  a_unmapped_rd: assert property (
    rd && (addr == 4'hf) |=> rdata == 16'h0000)
    else $error("unmapped word did not read zero");

  a_run0_ignored: assert property (
    wr_sys && !wdata[SYS_RUN] && (state == ST_IDLE) |=> !engine_run)
    else $error("run bit write of zero started drawing");

  a_halt_holds: assert property (
    (state == ST_HALT) && !run_req |=> (state == ST_HALT))
    else $error("halted engine left halt without run");

  a_trap_idle: assert property (
    trap_hit && !running && !wr_stat |=> $stable(flags[ST_TRAP]))
    else $error("trap taken while not running");

  a_dbm_write: assert property (
    wr_sys |=> double_buffer_mode_field == $past(wdata[SYS_DBM +: 2]))
    else $error("double buffer mode not written");

  a_ctx_read: assert property (
    rd && (addr == ADR_RC2) |=> rdata == $past(u_snap.mem[0]))
    else $error("context word read wrong");

  a_snap_hold: assert property (
    !take_brk |=> $stable(u_snap.mem[0]))
    else $error("context changed without a break");

  a_run_level: assert property (
    engine_run == (state == ST_RUN))
    else $error("run bit does not follow run state");

  a_irq_falls: assert property (
    wr_stat && (wdata[1:0] == flags) && !take_brk && !trap_end && !wr_mask
    |=> !irq)
    else $error("interrupt stayed up after clear");

  a_pend_clr: assert property (
    take_brk |=> !brk_pend)
    else $error("break request still pending after halt");

  // ------------------------------------------------------------
  // scenario covers
  // ------------------------------------------------------------
  c_irq: cover property (irq);
  c_ctx_rd: cover property (rd && in_rc2);
  c_break: cover property (take_brk);
  c_trap: cover property (trap_end);
  c_resume: cover property ((state == ST_HALT) ##[1:20] engine_run);
endmodule
`default_nettype wire

// *** test/dsrc_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// drawing engine stand-in: one command at a time, trap on demand
module dsrc_engine_model
  import dsrc_pkg::*;
#(
  parameter int N = RC2_WORDS
) (
  // clock
  input  wire logic                 clk,
  // from block and bench
  input  wire logic                 engine_run,
  input  wire logic                 cmd_go,
  input  wire logic                 do_trap,
  // to block
  output var  logic                 top_of_cmd,
  output var  logic                 trap_hit,
  output var  logic [N*DSRC_DW-1:0] engine_state
);
  logic waiting;

  initial
  begin
    top_of_cmd = 1'b0;
    trap_hit = 1'b0;
    waiting = 1'b0;
  end

  always_comb
  begin
    for (int i = 0; i < N; i++)
      engine_state[16*i +: 16] = 16'hc000 + 16'(i);
  end

  // waits for cmd_go before the next command top
  always @(posedge clk)
  begin
    top_of_cmd <= 1'b0;
    trap_hit <= 1'b0;
    if (engine_run !== 1'b1)
      waiting <= 1'b0;
    else if (top_of_cmd)
      waiting <= 1'b1;
    else if (waiting)
      waiting <= !cmd_go;
    else if (trap_hit)
      waiting <= 1'b0;
    else if (do_trap)
      trap_hit <= 1'b1;
    else
      top_of_cmd <= 1'b1;
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dsrc_pkg::*;
;
  logic                         clk;
  logic                         rstn;
  logic [DSRC_AW-1:0]           addr;
  logic [DSRC_DW-1:0]           wdata;
  logic                         wr;
  logic                         rd;
  logic [DSRC_DW-1:0]           rdata;
  logic                         top_of_cmd;
  logic                         trap_hit;
  logic [RC2_WORDS*DSRC_DW-1:0] engine_state;
  logic                         engine_run;
  logic                         cmd_go;
  logic                         irq;
  logic                         do_trap;
  int                           fail_count;
  int                           n_checks;
  int                           n_go;
  int                           cycles;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dsrc_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .top_of_cmd(top_of_cmd), .trap_hit(trap_hit),
    .engine_state(engine_state), .engine_run(engine_run), .cmd_go(cmd_go), .irq(irq));

  dsrc_engine_model u_eng (.clk(clk), .engine_run(engine_run), .cmd_go(cmd_go),
    .do_trap(do_trap), .top_of_cmd(top_of_cmd), .trap_hit(trap_hit),
    .engine_state(engine_state));

  task automatic close_out;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp, "read");
  endtask

  task automatic chk_irq(input logic exp);
    @(posedge clk);
    @(negedge clk);
    chk(16'(irq), 16'(exp), "irq");
  endtask

  task automatic wait_halt;
    int i;
    i = 0;
    while (engine_run !== 1'b0 && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    chk(16'(engine_run), 16'h0000, "no halt");
  endtask

  always @(posedge clk)
  begin
    if (cmd_go === 1'b1)
      n_go++;
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out;
    end
  end

  initial
  begin
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    do_trap = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(ADR_SYSCTL, 16'h0000);
    rd_reg(ADR_STATUS, 16'h0000);
    rd_reg(ADR_MASK, 16'h0000);
    wr_reg(4'h3, 16'hffff);
    rd_reg(4'h3, 16'h0000);
    // suspend in manual display change mode
    wr_reg(ADR_MASK, 16'h0003);
    wr_reg(ADR_SYSCTL, 16'h0009);
    rd_reg(ADR_SYSCTL, 16'h0009);
    wr_reg(ADR_SYSCTL, 16'h000a);
    wait_halt;
    chk(16'(n_go > 0), 16'h0001, "no command");
    rd_reg(ADR_STATUS, 16'h0001);
    chk_irq(1'b1);
    rd_reg(ADR_SYSCTL, 16'h0008);
    for (int i = 0; i < RC2_WORDS; i++)
      rd_reg(ADR_RC2 + 4'(i), 16'hc000 + 16'(i));
    wr_reg(ADR_STATUS, 16'h0001);
    rd_reg(ADR_STATUS, 16'h0000);
    chk_irq(1'b0);
    // resume, then a break outside manual mode is ignored
    n_go = 0;
    wr_reg(ADR_SYSCTL, 16'h0009);
    repeat (6) @(posedge clk);
    chk(16'(n_go > 0), 16'h0001, "no resume");
    wr_reg(ADR_SYSCTL, 16'h0002);
    repeat (10) @(negedge clk);
    chk(16'(engine_run), 16'h0001, "halted");
    rd_reg(ADR_SYSCTL, 16'h0001);
    rd_reg(ADR_STATUS, 16'h0000);
    // trap ends the list
    @(posedge clk);
    do_trap <= 1'b1;
    wait_halt;
    do_trap <= 1'b0;
    rd_reg(ADR_STATUS, 16'h0002);
    chk_irq(1'b1);
    wr_reg(ADR_MASK, 16'h0001);
    chk_irq(1'b0);
    wr_reg(ADR_STATUS, 16'h0002);
    rd_reg(ADR_STATUS, 16'h0000);
    close_out;
  end

  initial
  begin
    fail_count = 0;
    n_checks = 0;
    n_go = 0;
    cycles = 0;
  end
endmodule
`default_nettype wire
